// >>> shared/ebac_pkg.sv
/*
 * Constants for the byte-wide nonvolatile data store controller:
 * I/O offsets, control bit positions, operation encodings, timings.
 * Assumes an 8-bit core I/O port on a 10 MHz clock.
 */
package ebac_pkg;
    // I/O offsets; none are printed, so these are arbitrary but fixed
    localparam logic [5:0] OFS_CONTROL   = 6'h1F;
    localparam logic [5:0] OFS_DATA      = 6'h20;
    localparam logic [5:0] OFS_ADDR_LOW  = 6'h21;
    localparam logic [5:0] OFS_ADDR_HIGH = 6'h22;
    localparam logic [7:0] DATA_SPACE_OFS = 8'h20;
    localparam logic [5:0] BITOP_LIMIT    = 6'h1F;

    // Control register bit positions
    localparam int BIT_READ  = 0;
    localparam int BIT_START = 1;
    localparam int BIT_ARM   = 2;
    localparam int BIT_OPLO  = 4;
    localparam int BIT_OPHI  = 5;

    localparam logic [1:0] OP_COMBINED  = 2'h0;
    localparam logic [1:0] OP_ERASE     = 2'h1;
    localparam logic [1:0] OP_WRITE     = 2'h2;
    localparam logic [1:0] OP_RESERVED  = 2'h3;

    localparam logic [7:0] DATA_RESET   = 8'h00;
    localparam int ADDR_W = 9;
    localparam int DEPTH  = 512;

    localparam logic [2:0] ARM_CYCLES   = 3'h4;
    localparam logic [2:0] READ_STALL   = 3'h4;
    localparam logic [2:0] START_STALL  = 3'h2;

    // Programming times in microseconds, typical
    localparam int T_COMBINED_US = 3400;
    localparam int T_SPLIT_US    = 1800;

    typedef enum logic [1:0] {
        EB_IDLE,
        EB_ERASE,
        EB_WRITE
    } ebac_state_t;
endpackage

// >>> design/ebac_osc_tick.sv
/*
 * Tick generator from the calibrated oscillator clock.
 * Assumes osc_tick_in is a one-cycle pulse per oscillator period,
 * already in the mclk domain.
 */
`timescale 1ns/100ps
module ebac_osc_tick
    import ebac_pkg::*;
(
    input  wire logic        mclk,        // System clock
    input  wire logic        rst,         // Async reset, high
    input  wire logic        osc_tick_in, // Oscillator period pulse
    input  wire logic        run,         // Counting enabled
    input  wire logic [23:0] target,      // Ticks to count
    output logic             done         // One-cycle completion pulse
);
    logic [23:0] cnt_r;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_r <= 24'h00_0000;
        end else if (!run) begin
            cnt_r <= 24'h00_0000;
        end else if (osc_tick_in) begin
            // Restart on completion so a following phase gets its full time
            if (done) begin
                cnt_r <= 24'h00_0000;
            end else begin
                cnt_r <= cnt_r + 24'h00_0001;
            end
        end
    end

    assign done = run && osc_tick_in && (cnt_r + 24'h00_0001 >= target);
endmodule // ebac_osc_tick

// >>> design/ebac_ctrl.sv
/*
 * Nonvolatile data byte access controller on the core I/O port.
 * Holds address, data and control registers, runs erase and write
 * sequences timed by the calibrated oscillator, and serves reads.
 * Assumes the core honours io_stall and an array model sits on
 * the nv_* pins. Programming survives a reset; rst_prog is the
 * power-on reset that alone may abort it.
 */
// Function
// RULE1 - Mode 00 armed start: erase then write
// RULE2 - Mode 01 armed start: erase only
// RULE3 - Mode 10 armed start: write only
// RULE4 - Start flag reads one until done
// RULE5 - No new access while programming
// RULE6 - Host erases before write-only use
// RULE7 - Timing from calibrated oscillator ticks
// RULE8 - Reset does not abort running program
// RULE9 - Nine-bit address, high bits read zero
// RULE10 - Address undefined at reset, host loads
// RULE11 - Linear byte addressing from zero
// RULE12 - Data register: write source, read result
// RULE13 - Host read sequence polls start flag
// RULE14 - Host write sequence polls busy
// RULE15 - Data-space alias at I/O plus 0x20
// RULE16 - Bit set/clear touches one bit
// RULE17 - Host writes reserved bits as zero
// RULE18 - Arm flag self-clears after four cycles
// RULE19 - Mode locked while busy, reset 00
// RULE20 - Stall four on read, two start
// RULE21 - No read or address change busy
// RULE22 - Mode durations are tick parameters
// RULE23 - Operands captured only while idle
`timescale 1ns/100ps
module ebac_ctrl
    import ebac_pkg::*;
#(
    parameter logic [23:0] TICKS_COMBINED = 24'h00_0D48, // 3400 us
    parameter logic [23:0] TICKS_SPLIT    = 24'h00_0708  // 1800 us
) (
    input  wire logic        mclk,         // System clock 10 MHz
    input  wire logic        rst,          // Core reset, async high
    input  wire logic        rst_prog,     // Power-on reset, async high
    input  wire logic        osc_tick,     // Calibrated oscillator tick
    input  wire logic [7:0]  io_addr,      // Address, I/O or data space
    input  wire logic        io_dspace,    // Address is data space
    input  wire logic        io_wr,        // Byte write strobe
    input  wire logic        io_rd,        // Byte read strobe
    input  wire logic        io_bitset,    // Single-bit set
    input  wire logic        io_bitclr,    // Single-bit clear
    input  wire logic [2:0]  io_bitsel,    // Bit for set/clear
    input  wire logic [7:0]  io_wdata,     // Write data
    output logic [7:0]       io_rdata,     // Read data
    output logic             io_stall,     // Halt core
    output logic [8:0]       nv_addr,      // Array byte address
    output logic [7:0]       nv_wdata,     // Array write data
    output logic             nv_erase,     // Array erasing
    output logic             nv_program,   // Array writing
    input  wire logic [7:0]  nv_rdata      // Array read data
);
    logic [7:0]  addr_low_r;
    logic        addr_bit8_r;
    logic [7:0]  data_r;
    logic [1:0]  op_r;
    logic        arm_r;
    logic [2:0]  arm_cnt_r;
    logic [2:0]  stall_r;
    ebac_state_t state_r;
    logic        phase_done;
    logic [23:0] phase_target;
    logic [5:0]  ioa;
    logic        hit;
    logic [7:0]  cur;
    logic [7:0]  wv;
    logic        busy;
    logic        wr_ctl;
    logic        wr_any;

    // Data-space addresses map back to the I/O offset
    always_comb begin
        ioa = io_addr[5:0];
        hit = !io_dspace && io_addr < 8'h40;
        if (io_dspace) begin
            ioa = 6'((io_addr - DATA_SPACE_OFS));           // RULE15
            hit = io_addr >= DATA_SPACE_OFS && io_addr < 8'h60;
        end
    end

    assign busy = (state_r != EB_IDLE);                    // RULE4

    // Current control byte: reserved bits and the read strobe read zero
    always_comb begin
        cur = 8'h00;
        cur[BIT_START] = busy;
        cur[BIT_ARM]   = arm_r;
        cur[BIT_OPLO]  = op_r[0];
        cur[BIT_OPHI]  = op_r[1];
    end

    // Bit ops affect only the chosen bit; read strobe reads zero so
    // a bit op never re-fires it
    always_comb begin
        wv = io_wdata;
        if (io_bitset) begin
            wv = cur | (8'h01 << io_bitsel);               // RULE16
        end else if (io_bitclr) begin
            wv = cur & ~(8'h01 << io_bitsel);              // RULE16
        end
    end

    assign wr_any = hit && (io_wr ||
                    ((io_bitset || io_bitclr) && ioa <= BITOP_LIMIT));
    assign wr_ctl = wr_any && ioa == OFS_CONTROL;

    // Address held across core reset: no defined reset value
    always_ff @(posedge mclk) begin
        if (wr_any && !busy && ioa == OFS_ADDR_LOW) begin  // RULE21
            addr_low_r <= wv;                              // RULE10
        end
    end

    always_ff @(posedge mclk) begin
        if (wr_any && !busy && ioa == OFS_ADDR_HIGH) begin // RULE23
            addr_bit8_r <= wv[0];                          // RULE9
        end
    end

    // Kept through a core reset while programming, so a write in
    // flight still programs the byte that was loaded
    always_ff @(posedge mclk or posedge rst_prog) begin
        if (rst_prog) begin
            data_r <= DATA_RESET;
        end else if (rst && !busy) begin
            data_r <= DATA_RESET;                          // RULE8
        end else if (wr_ctl && wv[BIT_READ] && !busy) begin
            data_r <= nv_rdata;                            // RULE12
        end else if (wr_any && !busy && ioa == OFS_DATA) begin
            data_r <= wv;                                  // RULE23
        end
    end

    // Arm flag with four-cycle window
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            arm_r     <= 1'b0;
            arm_cnt_r <= 3'h0;
        end else if (wr_ctl && wv[BIT_ARM] && !arm_r) begin
            arm_r     <= 1'b1;
            arm_cnt_r <= ARM_CYCLES - 3'h1;
        end else if (arm_r) begin
            if (arm_cnt_r == 3'h0) begin
                arm_r <= 1'b0;                             // RULE18
            end else begin
                arm_cnt_r <= arm_cnt_r - 3'h1;
            end
        end
    end

    // Mode field; kept through a core reset while programming
    always_ff @(posedge mclk or posedge rst_prog) begin
        if (rst_prog) begin
            op_r <= OP_COMBINED;
        end else if (rst && !busy) begin
            op_r <= OP_COMBINED;                           // RULE19
        end else if (wr_ctl && !busy && !rst) begin
            op_r <= {wv[BIT_OPHI], wv[BIT_OPLO]};          // RULE19
        end
    end

    // Sequencer on the programming reset only, so core reset lets
    // a running operation finish
    always_ff @(posedge mclk or posedge rst_prog) begin
        if (rst_prog) begin
            state_r <= EB_IDLE;
        end else begin
            unique case (state_r)
                EB_IDLE: begin
                    // Reserved mode starts nothing
                    if (!rst && wr_ctl && wv[BIT_START] && arm_r) begin
                        if (op_r == OP_COMBINED || op_r == OP_ERASE) begin
                            state_r <= EB_ERASE;           // RULE1 RULE2
                        end else if (op_r == OP_WRITE) begin
                            state_r <= EB_WRITE;           // RULE3
                        end
                    end
                end
                EB_ERASE: begin
                    if (phase_done) begin
                        state_r <= (op_r == OP_COMBINED) ? EB_WRITE
                                                         : EB_IDLE;
                    end
                end
                EB_WRITE: begin
                    if (phase_done) begin
                        state_r <= EB_IDLE;                // RULE4 RULE8
                    end
                end
            endcase
        end
    end

    // Combined time splits evenly between its two phases
    always_comb begin
        if (op_r == OP_COMBINED) begin
            phase_target = TICKS_COMBINED >> 1;            // RULE22
        end else begin
            phase_target = TICKS_SPLIT;                    // RULE22
        end
    end

    ebac_osc_tick u_tick (
        .mclk        (mclk),
        .rst         (rst_prog),
        .osc_tick_in (osc_tick),                           // RULE7
        .run         (busy),
        .target      (phase_target),
        .done        (phase_done)
    );

    // Core stall after read or start
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stall_r <= 3'h0;
        end else if (wr_ctl && wv[BIT_READ] && !busy) begin
            stall_r <= READ_STALL;                         // RULE20
        end else if (wr_ctl && wv[BIT_START] && arm_r && !busy
                     && op_r != OP_RESERVED) begin
            stall_r <= START_STALL;                        // RULE20
        end else if (stall_r != 3'h0) begin
            stall_r <= stall_r - 3'h1;
        end
    end

    assign io_stall = (stall_r != 3'h0);

    always_comb begin
        io_rdata = 8'h00;
        if (hit && io_rd) begin
            unique case (ioa)
                OFS_CONTROL:   io_rdata = cur;
                OFS_DATA:      io_rdata = data_r;
                OFS_ADDR_LOW:  io_rdata = addr_low_r;
                OFS_ADDR_HIGH: io_rdata = {7'h00, addr_bit8_r}; // RULE9
                default:       io_rdata = 8'h00;
            endcase
        end
    end

    assign nv_addr    = {addr_bit8_r, addr_low_r};         // RULE11
    assign nv_wdata   = data_r;
    assign nv_erase   = (state_r == EB_ERASE);             // RULE5
    assign nv_program = (state_r == EB_WRITE);
endmodule // ebac_ctrl

// >>> test/ebac_array_model.sv
/* Byte array model on the controller's nv pins.
   Assumes the phases hold for several clocks; repeats are harmless. */
`timescale 1ns/100ps
module ebac_array_model
    import ebac_pkg::*;
(
    input  wire logic       mclk,       // System clock
    input  wire logic [8:0] nv_addr,    // Byte address
    input  wire logic [7:0] nv_wdata,   // Byte to program
    input  wire logic       nv_erase,   // Erase phase
    input  wire logic       nv_program, // Write phase
    output logic      [7:0] nv_rdata    // Byte at address
);
    logic [7:0] mem_r [DEPTH];
    always @(posedge mclk) begin
        if (nv_erase) begin
            mem_r[nv_addr] <= 8'hFF;
        end
        // Programming only clears bits, so an unerased byte is corrupted
        if (nv_program) begin
            mem_r[nv_addr] <= mem_r[nv_addr] & nv_wdata;
        end
    end
    assign nv_rdata = mem_r[nv_addr];
endmodule // ebac_array_model

// >>> test/ebac_ctrl_sva.sv
/* Port assertions for the access controller.
   Bound to every ebac_ctrl instance. */
`timescale 1ns/100ps
module ebac_ctrl_sva
    import ebac_pkg::*;
(
    input wire logic       mclk,       // Clock
    input wire logic       rst,        // Core reset
    input wire logic       rst_prog,   // Power-on reset
    input wire logic [7:0] io_addr,    // Address
    input wire logic       io_dspace,  // Data space
    input wire logic       io_wr,      // Write strobe
    input wire logic       io_rd,      // Read qualifier
    input wire logic [7:0] io_wdata,   // Write data
    input wire logic [7:0] io_rdata,   // Read data
    input wire logic       io_stall,   // Core halt
    input wire logic [8:0] nv_addr,    // Array address
    input wire logic [7:0] nv_wdata,   // Array data
    input wire logic       nv_erase,   // Erase phase
    input wire logic       nv_program  // Write phase
);
    logic busy;
    logic ctl_wr;
    assign busy = nv_erase | nv_program;
    assign ctl_wr = io_wr & ((!io_dspace & io_addr == {2'h0, OFS_CONTROL})
        | (io_dspace & io_addr == DATA_SPACE_OFS + OFS_CONTROL));
    default clocking @(posedge mclk); endclocking
    default disable iff (rst || rst_prog);
    sequence read_req;
        ctl_wr && io_wdata[BIT_READ] && !busy;
    endsequence
    sequence stall4;
        io_stall [*4] ##1 !io_stall;
    endsequence
    sequence stall2;
        io_stall [*2] ##1 !io_stall;
    endsequence
    a_read_stall: assert property (read_req |=> stall4)
        else $error("read stall length wrong");
    a_start_stall: assert property ($rose(busy) |-> stall2)
        else $error("start stall length wrong");
    a_phase_excl: assert property (!(nv_erase && nv_program))
        else $error("erase and write overlap");
    a_operand_hold: assert property (
        busy ##1 busy |-> $stable(nv_addr) && $stable(nv_wdata))
        else $error("operands moved while busy");
    a_high_zero: assert property (
        io_rd && !io_dspace && io_addr == {2'h0, OFS_ADDR_HIGH}
        |-> io_rdata == {7'h00, nv_addr[8]})
        else $error("address high read wrong");
    a_data_alias: assert property (
        io_rd && io_dspace && io_addr == DATA_SPACE_OFS + OFS_DATA
        |-> io_rdata == nv_wdata)
        else $error("data space alias wrong");
    a_busy_start: assert property (busy && io_rd && !io_dspace
        && io_addr == {2'h0, OFS_CONTROL} |-> io_rdata[BIT_START])
        else $error("start flag low while busy");
    a_read_refused: assert property (busy ##1 busy ##1 busy && ctl_wr
        && io_wdata[BIT_READ] |=> !io_stall)
        else $error("read taken while busy");
endmodule // ebac_ctrl_sva
bind ebac_ctrl ebac_ctrl_sva u_sva (.mclk(mclk), .rst(rst),
    .rst_prog(rst_prog),
    .io_addr(io_addr), .io_dspace(io_dspace), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_stall(io_stall),
    .nv_addr(nv_addr), .nv_wdata(nv_wdata), .nv_erase(nv_erase),
    .nv_program(nv_program));

// >>> test/ebac_ctrl_bench.sv
/* Self-checking bench: drives the controller as the core would.
   Assumes the array model on the nv pins and the bound checker. */
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module ebac_ctrl_bench;
    import ebac_pkg::*;
    localparam logic [8:0] CT = {3'h0, OFS_CONTROL};
    localparam logic [8:0] DT = {3'h0, OFS_DATA};
    localparam logic [8:0] AL = {3'h0, OFS_ADDR_LOW};
    localparam logic [8:0] AH = {3'h0, OFS_ADDR_HIGH};
    logic       mclk = 1'b0, rst = 1'b1, rst_prog = 1'b1, osc_tick = 1'b0;
    logic       io_dspace = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
    logic       io_bitset = 1'b0, io_bitclr = 1'b0;
    logic       io_stall, nv_erase, nv_program;
    logic [7:0] io_addr = 8'h00, io_wdata = 8'h00;
    logic [7:0] io_rdata, nv_wdata, nv_rdata;
    logic [2:0] io_bitsel = 3'h0;
    logic [8:0] nv_addr;
    int         n_fail = 0, cmp_count = 0;
    ebac_ctrl #(
        .TICKS_COMBINED (24'h00_0020),
        .TICKS_SPLIT    (24'h00_0010)
    ) dut (
        .mclk(mclk), .rst(rst), .rst_prog(rst_prog), .osc_tick(osc_tick),
        .io_addr(io_addr), .io_dspace(io_dspace), .io_wr(io_wr), .io_rd(io_rd),
        .io_bitset(io_bitset), .io_bitclr(io_bitclr), .io_bitsel(io_bitsel),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .io_stall(io_stall),
        .nv_addr(nv_addr), .nv_wdata(nv_wdata), .nv_erase(nv_erase),
        .nv_program(nv_program), .nv_rdata(nv_rdata));
    ebac_array_model u_arr (.mclk(mclk), .nv_addr(nv_addr), .nv_wdata(nv_wdata),
        .nv_erase(nv_erase), .nv_program(nv_program), .nv_rdata(nv_rdata));
    initial forever #50 mclk = ~mclk;
    initial forever begin
        @(posedge mclk);
        #10 osc_tick = ~osc_tick;
    end
    // The core issues nothing while halted
    task automatic step();
        @(posedge mclk);
        #10;
        while (io_stall) begin
            @(posedge mclk);
            #10;
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        step();
        {io_dspace, io_addr} = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(posedge mclk);
        #10 io_wr = 1'b0;
    endtask
    task automatic rd(input logic [8:0] a, output logic [7:0] v);
        step();
        {io_dspace, io_addr} = a;
        io_rd = 1'b1;
        #80 v = io_rdata;
        @(posedge mclk);
        #10 io_rd = 1'b0;
    endtask
    task automatic bit_set(input int n);
        step();
        {io_dspace, io_addr} = CT;
        io_bitsel = 3'(n);
        io_bitset = 1'b1;
        @(posedge mclk);
        #10 io_bitset = 1'b0;
    endtask
    task automatic bit_clr(input int n);
        step();
        {io_dspace, io_addr} = CT;
        io_bitsel = 3'(n);
        io_bitclr = 1'b1;
        @(posedge mclk);
        #10 io_bitclr = 1'b0;
    endtask
    task automatic wait_idle(output logic [7:0] v);
        int n = 0;
        do begin
            rd(CT, v);
            n++;
        end while (v[BIT_START] !== 1'b0 && n < 100);
        `CHK(v[BIT_START], 1'b0)
    endtask
    task automatic prog(input logic [1:0] m, input logic [7:0] d,
                        input logic [7:0] e);
        logic [7:0] v;
        wr(DT, d);
        wr(CT, {2'h0, m, 4'h0});
        bit_set(BIT_ARM);
        bit_set(BIT_START);
        rd(CT, v);
        `CHK(v[BIT_START], 1'b1)
        `CHK(v[5:4], m)
        wr(AL, 8'h00);
        wr(DT, 8'h00);
        wr(CT, 8'h01);
        `CHK(nv_addr, 9'h15A)
        `CHK(nv_wdata, d)
        wait_idle(v);
        `CHK(v[5:4], m)
        wr({1'b1, DATA_SPACE_OFS + 8'(OFS_CONTROL)}, {2'h0, m, 4'h1});
        rd({1'b1, DATA_SPACE_OFS + 8'(OFS_DATA)}, v);
        `CHK(v, e)
    endtask
    task automatic report_and_stop();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge mclk);
        n_fail++;
        report_and_stop();
    end
    initial begin
        logic [7:0] v;
        repeat (5) @(posedge mclk);
        #10;
        rst = 1'b0;
        rst_prog = 1'b0;
        rd(DT, v);
        `CHK(v, DATA_RESET)
        wr(AH, 8'hFF);
        wr(AL, 8'h5A);
        rd(AH, v);
        `CHK(v, 8'h01)
        rd(AL, v);
        `CHK(v, 8'h5A)
        prog(OP_ERASE, 8'h00, 8'hFF);
        prog(OP_WRITE, 8'h3C, 8'h3C);
        prog(OP_COMBINED, 8'hC3, 8'hC3);
        wr(CT, 8'h02);
        rd(CT, v);
        `CHK(v[BIT_START], 1'b0)
        wr(CT, 8'h04);
        repeat (5) step();
        wr(CT, 8'h02);
        rd(CT, v);
        `CHK(v[BIT_START], 1'b0)
        wr(CT, 8'h30);
        wr(CT, 8'h34);
        wr(CT, 8'h32);
        rd(CT, v);
        `CHK(v[BIT_START], 1'b0)
        bit_clr(BIT_OPHI);
        rd(CT, v);
        `CHK(v[5:4], OP_ERASE)
        // Core reset mid-erase, then mid-write onto the erased byte
        for (int m = 1; m <= 2; m++) begin
            wr(DT, 8'h81);
            wr(CT, {2'h0, 2'(m), 4'h0});
            bit_set(BIT_ARM);
            bit_set(BIT_START);
            step();
            rst = 1'b1;
            step();
            rst = 1'b0;
            rd(CT, v);
            `CHK(v[BIT_START], 1'b1)
            `CHK(v[5:4], 2'(m))
            wait_idle(v);
        end
        wr(CT, 8'h21);
        rd(DT, v);
        `CHK(v, 8'h81)
        step();
        rst = 1'b1;
        step();
        rst = 1'b0;
        rd(CT, v);
        `CHK(v[5:4], OP_COMBINED)
        report_and_stop();
    end
endmodule // ebac_ctrl_bench
